// ---- dcw_pkg.sv ----
// Package for the drive command word decoder: register map, bit positions,
// command values, operating modes and the request carrier types.
// Assumes a single clock domain and a 32-bit AXI4-Lite register bus.
package dcw_pkg;

    // Bus geometry. Printed offsets are word indices; byte address is index times four.
    localparam int           AXI_ADDR_W   = 12;
    localparam logic [9:0]   AUX0_INDEX   = 10'h001;
    localparam logic [9:0]   CMD_INDEX    = 10'h38f;
    localparam logic [9:0]   MODE_INDEX   = 10'h391;
    localparam logic [9:0]   STATUS_INDEX = 10'h392;
    localparam logic [11:0]  AUX0_ADDR    = {AUX0_INDEX, 2'b00};
    localparam logic [11:0]  CMD_ADDR     = {CMD_INDEX, 2'b00};
    localparam logic [11:0]  MODE_ADDR    = {MODE_INDEX, 2'b00};
    localparam logic [11:0]  STATUS_ADDR  = {STATUS_INDEX, 2'b00};
    localparam logic [1:0]   RESP_OKAY    = 2'h0;
    localparam logic [1:0]   RESP_SLVERR  = 2'h2;

    // Stored bits of each register; everything else reads as zero.
    localparam logic [15:0]  CMD_KEEP_MASK  = 16'h3aff;
    localparam logic [15:0]  AUX0_KEEP_MASK = 16'h1fff;
    localparam logic [15:0]  CMD_RESET      = 16'h0000;
    localparam logic [15:0]  AUX0_RESET     = 16'h0000;
    localparam logic [7:0]   MODE_RESET     = 8'hff;

    // Command word bit positions.
    localparam int BIT_SWITCH_ON = 0;
    localparam int BIT_DISABLE   = 1;
    localparam int BIT_QSTOP     = 2;
    localparam int BIT_ENABLE    = 3;
    localparam int BIT_MS1       = 4;
    localparam int BIT_MS2       = 5;
    localparam int BIT_MS3       = 6;
    localparam int BIT_FAULT     = 7;
    localparam int BIT_MS4       = 9;
    localparam int BIT_BRAKE     = 11;
    localparam int BIT_NEG_LIM   = 12;
    localparam int BIT_POS_LIM   = 13;

    // Whole-word commands.
    localparam logic [15:0]  VAL_DISABLE_VOLTAGE = 16'h0004;
    localparam logic [15:0]  VAL_SHUTDOWN        = 16'h0006;
    localparam logic [15:0]  VAL_SWITCH_ON       = 16'h0007;
    localparam logic [15:0]  VAL_ENABLE_OP       = 16'h000f;
    localparam logic [15:0]  VAL_STOP            = 16'h0002;
    localparam logic [15:0]  VAL_START_HOMING    = 16'h001f;
    localparam logic [15:0]  VAL_END_HOMING      = 16'h000f;

    // Requested operating modes that change how mode-specific bits read.
    localparam logic [7:0]   MODE_HOMING = 8'h06;
    localparam logic [7:0]   MODE_JOG    = 8'h8c;

    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_SWITCH_ON_DISABLED,
        TGT_ARMED_IDLE,
        TGT_SWITCHED_ON,
        TGT_OPERATION_ENABLED,
        TGT_STOP_ACTIVE
    } dcw_target_type;

    typedef struct packed {
        dcw_target_type target;
        logic           target_valid;
        logic           fault_reset;
        logic           homing_start;
        logic           homing_end;
        logic           homing_active;
        logic           commanded_stop;
        logic           jog_plus;
        logic           jog_minus;
        logic [1:0]     jog_speed_sel;
        logic           dynamic_brake;
        logic           neg_limit;
        logic           pos_limit;
        logic [15:0]    aux_control;
    } dcw_drive_req_type;

    // Layout of the read-only status register, low bit last.
    typedef struct packed {
        dcw_target_type last_target;
        logic           pos_limit;
        logic           neg_limit;
        logic           dynamic_brake;
        logic [1:0]     jog_speed_sel;
        logic           jog_minus;
        logic           jog_plus;
        logic           homing_active;
        logic           commanded_stop;
    } dcw_status_type;

endpackage

// ---- dcw_axil_slave.sv ----
// AXI4-Lite slave front end: holds one write and one read, hands each to the
// register file as a one-cycle strobe and returns the response a cycle later.
// Assumes the register file answers hit and read data combinationally.
`timescale 1ns/1ps
module dcw_axil_slave
    import dcw_pkg::*;
#(
    parameter int ADDR_W = AXI_ADDR_W
)
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   wr_en,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_hit,
    output logic                   rd_en,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_hit
);

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              ar_held;
        logic [ADDR_W-1:0] ar_addr;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } dcw_axil_state_type;

    dcw_axil_state_type state_reg;
    dcw_axil_state_type state_next;

    // A write goes out only once address and data are both held, in either order.
    assign wr_en   = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;
    assign wr_addr = state_reg.aw_addr;
    assign wr_data = state_reg.w_data;
    assign wr_strb = state_reg.w_strb;
    assign rd_en   = state_reg.ar_held & ~state_reg.rvalid;
    assign rd_addr = state_reg.ar_addr;

    // Channel bookkeeping; ready drops while an item is held or a response waits.
    always_comb begin
        state_next = state_reg;
        if (state_reg.awready && s_axi_awvalid) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (state_reg.wready && s_axi_wvalid) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        if (wr_en) begin
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (state_reg.arready && s_axi_arvalid) begin
            state_next.ar_held = 1'b1;
            state_next.ar_addr = s_axi_araddr;
        end
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (rd_en) begin
            state_next.ar_held = 1'b0;
            state_next.rvalid  = 1'b1;
            state_next.rdata   = rd_hit ? rd_data : 32'h0000_0000;
            state_next.rresp   = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        state_next.awready = ~state_next.aw_held & ~state_next.bvalid;
        state_next.wready  = ~state_next.w_held & ~state_next.bvalid;
        state_next.arready = ~state_next.ar_held & ~state_next.rvalid;
    end

    // Synchronous reset clears every channel; ready rises one edge after release.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready  = state_reg.wready;
    assign s_axi_bvalid  = state_reg.bvalid;
    assign s_axi_bresp   = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rdata   = state_reg.rdata;
    assign s_axi_rresp   = state_reg.rresp;

endmodule

// ---- dcw_control_word_decoder.sv ----
// Drive command word decoder: register file behind AXI4-Lite and the logic
// that turns each written command word into requests for the drive state machine.
// Assumes the state machine, brake and limit actuators sit outside and act on
// the request outputs; one clock, synchronous active-low reset.
//
// Function
// - Fault reset pulses only on a 0-to-1 change of bit 7.
// - Writing 04 hex requests the switch-on-disabled state.
// - Writing 06 hex requests the armed idle state.
// - Writing 07 hex requests the switched-on state.
// - Writing 0F hex requests the operation-enabled state.
// - Writing 02 hex requests the stop-active state.
// - In homing mode 1F starts homing and 0F ends it.
// - Rising bit 0 requests the switched-on state.
// - Rising bit 1 requests the switch-on-disabled state.
// - Bit 2 low holds a commanded stop active.
// - Rising bit 3 requests the operation-enabled state.
// - In homing mode bit 4 level keeps homing running or ends it.
// - In jog mode bit 4 drives jog speed select bit 0.
// - In jog mode bit 5 drives the positive jog request.
// - In jog mode bit 6 drives the negative jog request.
// - In jog mode bit 9 drives jog speed select bit 1.
// - Reserved bits 8, 10, 14 and 15 are dropped and read zero.
// - Command word is 16-bit read/write, any value, lost at reset.
// - Mode-specific bits follow the separately written requested mode.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module dcw_control_word_decoder
    import dcw_pkg::*;
#(
    parameter int ADDR_W = AXI_ADDR_W
)
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output dcw_drive_req_type      drive_req
);

    // Whole state of the decoder in one record.
    typedef struct packed {
        logic [15:0]       cmd;
        logic [15:0]       aux;
        logic [7:0]        mode;
        dcw_target_type    last_target;
        dcw_drive_req_type req;
    } dcw_core_state_type;

    dcw_core_state_type state_reg;
    dcw_core_state_type state_next;

    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              wr_hit;
    logic              rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              rd_hit;

    // Bus front end; it owns all AXI handshakes and response timing.
    dcw_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_hit        (wr_hit),
        .rd_en         (rd_en),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_hit        (rd_hit)
    );

    // Merge the two low byte lanes of a write into a 16-bit register value.
    function automatic logic [15:0] merge16(
        input logic [15:0] old_value,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [15:0] result;
        result = old_value;
        if (strb[0]) begin
            result[7:0] = data[7:0];
        end
        if (strb[1]) begin
            result[15:8] = data[15:8];
        end
        return result;
    endfunction

    // Whole-word commands take precedence; a lone edge only acts when no value matches.
    function automatic dcw_target_type decode_target(
        input logic [15:0] word,
        input logic [15:0] rise
    );
        dcw_target_type tgt;
        tgt = TGT_NONE;
        if (word == VAL_DISABLE_VOLTAGE) begin
            tgt = TGT_SWITCH_ON_DISABLED;
        end else if (word == VAL_SHUTDOWN) begin
            tgt = TGT_ARMED_IDLE;
        end else if (word == VAL_SWITCH_ON) begin
            tgt = TGT_SWITCHED_ON;
        end else if (word == VAL_ENABLE_OP) begin
            tgt = TGT_OPERATION_ENABLED;
        end else if (word == VAL_STOP) begin
            tgt = TGT_STOP_ACTIVE;
        end else if (rise[BIT_DISABLE]) begin
            tgt = TGT_SWITCH_ON_DISABLED;
        end else if (rise[BIT_ENABLE]) begin
            tgt = TGT_OPERATION_ENABLED;
        end else if (rise[BIT_SWITCH_ON]) begin
            tgt = TGT_SWITCHED_ON;
        end
        return tgt;
    endfunction

    // Address decode for the write strobe; the status word is read-only and
    // a write to it answers with an error so software notices the mistake.
    always_comb begin
        wr_hit = 1'b0;
        if (wr_addr == CMD_ADDR || wr_addr == AUX0_ADDR || wr_addr == MODE_ADDR) begin
            wr_hit = 1'b1;
        end
    end

    // Read multiplexer; unmapped addresses answer with an error and zero data.
    always_comb begin
        dcw_status_type status;
        status               = '0;
        status.last_target   = state_reg.last_target;
        status.pos_limit     = state_reg.req.pos_limit;
        status.neg_limit     = state_reg.req.neg_limit;
        status.dynamic_brake = state_reg.req.dynamic_brake;
        status.jog_speed_sel = state_reg.req.jog_speed_sel;
        status.jog_minus     = state_reg.req.jog_minus;
        status.jog_plus      = state_reg.req.jog_plus;
        status.homing_active = state_reg.req.homing_active;
        status.commanded_stop = state_reg.req.commanded_stop;
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (rd_addr)
            CMD_ADDR: begin
                rd_data = {16'h0000, state_reg.cmd};
            end
            AUX0_ADDR: begin
                rd_data = {16'h0000, state_reg.aux};
            end
            MODE_ADDR: begin
                rd_data = {24'h00_0000, state_reg.mode};
            end
            STATUS_ADDR: begin
                rd_data = {20'h0_0000, status};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Next-state logic. Pulses default low so each lasts exactly one cycle;
    // levels are rebuilt every cycle from the stored word and mode, so a mode
    // change reinterprets the held bits without waiting for a new command.
    always_comb begin
        logic [15:0] new_word;
        logic [15:0] rise;
        logic        homing_mode;
        logic        jog_mode;
        state_next                  = state_reg;
        new_word                    = state_reg.cmd;
        rise                        = 16'h0000;
        homing_mode                 = 1'b0;
        jog_mode                    = 1'b0;
        state_next.req.target       = TGT_NONE;
        state_next.req.target_valid = 1'b0;
        state_next.req.fault_reset  = 1'b0;
        state_next.req.homing_start = 1'b0;
        state_next.req.homing_end   = 1'b0;

        // Requested-mode register; the state machine may adopt it later.
        if (wr_en && wr_addr == MODE_ADDR && wr_strb[0]) begin
            state_next.mode = wr_data[7:0];
        end

        // Auxiliary control word keeps bits 12 to 0 only and is presented as stored.
        if (wr_en && wr_addr == AUX0_ADDR) begin
            state_next.aux = merge16(state_reg.aux, wr_data, wr_strb) & AUX0_KEEP_MASK;
        end

        // The interpretation of mode-specific bits uses the requested mode as it
        // stands each cycle, a write in that cycle included, not the state machine's actual mode.
        homing_mode = (state_next.mode == MODE_HOMING);
        jog_mode    = (state_next.mode == MODE_JOG);

        if (wr_en && wr_addr == CMD_ADDR) begin
            // Any 16-bit value is accepted; reserved lanes are simply not kept.
            new_word = merge16(state_reg.cmd, wr_data, wr_strb) & CMD_KEEP_MASK;
            // Edges are taken against the word held from the previous write.
            rise = new_word & ~state_reg.cmd;
            state_next.cmd = new_word;
            state_next.req.target = decode_target(new_word, rise);
            state_next.req.target_valid = (decode_target(new_word, rise) != TGT_NONE);
            if (decode_target(new_word, rise) != TGT_NONE) begin
                state_next.last_target = decode_target(new_word, rise);
            end
            // Holding bit 7 high across writes gives no second pulse.
            state_next.req.fault_reset = rise[BIT_FAULT];
            if (homing_mode && new_word == VAL_START_HOMING) begin
                state_next.req.homing_start = 1'b1;
            end
            if (homing_mode && new_word == VAL_END_HOMING && state_reg.cmd[BIT_MS1]) begin
                state_next.req.homing_end = 1'b1;
            end
        end

        // Levels driven straight from the held word.
        state_next.req.commanded_stop = ~state_next.cmd[BIT_QSTOP];
        state_next.req.dynamic_brake  = state_next.cmd[BIT_BRAKE];
        state_next.req.neg_limit      = state_next.cmd[BIT_NEG_LIM];
        state_next.req.pos_limit      = state_next.cmd[BIT_POS_LIM];

        // Mode-specific levels; outside their mode they rest low.
        state_next.req.homing_active    = homing_mode & state_next.cmd[BIT_MS1];
        state_next.req.jog_speed_sel[0] = jog_mode & state_next.cmd[BIT_MS1];
        state_next.req.jog_plus         = jog_mode & state_next.cmd[BIT_MS2];
        state_next.req.jog_minus        = jog_mode & state_next.cmd[BIT_MS3];
        state_next.req.jog_speed_sel[1] = jog_mode & state_next.cmd[BIT_MS4];

        state_next.req.aux_control = state_next.aux;
    end

    // The command word is volatile: reset returns it to zero, which by itself
    // asks for a commanded stop until software writes bit 2 high.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg                    <= '0;
            state_reg.cmd                <= CMD_RESET;
            state_reg.aux                <= AUX0_RESET;
            state_reg.mode               <= MODE_RESET;
            state_reg.last_target        <= TGT_NONE;
            state_reg.req.target         <= TGT_NONE;
            state_reg.req.commanded_stop <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Every request output is a register field.
    assign drive_req = state_reg.req;

endmodule

// ---- dcw_axil_master.sv ----
// Bus master model standing for the network master on the register bus.
// Assumes the tb calls its tasks one at a time from a single process.
`timescale 1ns/1ps
module dcw_axil_master
(
    input  wire logic   aclk,
    output logic [11:0] s_axi_awaddr = 12'h0,
    output logic        s_axi_awvalid = 1'b0,
    input  wire logic   s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic [3:0]  s_axi_wstrb = 4'hf,
    output logic        s_axi_wvalid = 1'b0,
    input  wire logic   s_axi_wready,
    input  wire logic   s_axi_bvalid,
    output logic        s_axi_bready = 1'b0,
    output logic [11:0] s_axi_araddr = 12'h0,
    output logic        s_axi_arvalid = 1'b0,
    input  wire logic   s_axi_arready,
    input  wire logic   s_axi_rvalid,
    output logic        s_axi_rready = 1'b0
);
    // Response ready goes up with the request and drops at the edge the answer is seen.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit pa = 1, pw = 1;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            s_axi_awvalid <= pa;
            s_axi_wvalid  <= pw;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    // Read follows the same pattern; the data is taken at the answer edge.
    task automatic rd(input logic [11:0] a);
        bit pa = 1;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            pa = pa && !s_axi_arready;
            s_axi_arvalid <= pa;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
endmodule

// ---- dcw_properties.sv ----
// Checker for bus answers and drive request pulses of the decoder.
// Sees only top ports; bound from the testbench top file.
`timescale 1ns/1ps
module dcw_properties
    import dcw_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire dcw_drive_req_type drive_req
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Every pulse is born with the response of the write that caused it.
    sequence s_resp; $rose(s_axi_bvalid); endsequence
    property p_fault; drive_req.fault_reset |-> s_resp ##1 !drive_req.fault_reset; endproperty
    property p_tgt; drive_req.target_valid |-> s_resp ##1 !drive_req.target_valid; endproperty
    property p_code; drive_req.target_valid |-> drive_req.target != TGT_NONE; endproperty
    property p_hs; drive_req.homing_start |-> drive_req.homing_active ##0 s_resp; endproperty
    property p_he; drive_req.homing_end |-> drive_req.target_valid && !drive_req.homing_active
        && drive_req.target == TGT_OPERATION_ENABLED; endproperty
    property p_mode; (drive_req.jog_plus || drive_req.jog_speed_sel != 2'h0) |-> !drive_req.homing_active;
    endproperty
    property p_bh; s_axi_bvalid |=> $past(s_axi_bready) ? !s_axi_bvalid : s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rh; s_axi_rvalid |=> $past(s_axi_rready) ? !s_axi_rvalid : s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_fault: assert property (p_fault) else $error("fault reset pulse wrong");
    a_tgt: assert property (p_tgt) else $error("target pulse wrong");
    a_code: assert property (p_code) else $error("empty target");
    a_hs: assert property (p_hs) else $error("homing start wrong");
    a_he: assert property (p_he) else $error("homing end wrong");
    a_mode: assert property (p_mode) else $error("jog level outside jog");
    a_bh: assert property (p_bh) else $error("write answer dropped");
    a_rh: assert property (p_rh) else $error("read answer dropped");
endmodule

// ---- tb.sv ----
// Testbench top: resets the decoder, drives it through the bus model and
// checks answers and drive requests. Assumes dcw_pkg and the bus model.
`timescale 1ns/1ps
module tb
    import dcw_pkg::*;
;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [11:0]       s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready;
    dcw_drive_req_type drive_req;
    dcw_target_type    tg;
    logic [33:0]       exp_q[$];
    logic [31:0]       r = 32'h3b;
    int                fails, comparisons, nf, hs, he, cyc;
    logic [15:0]       tw [10] = '{16'h4, 16'h6, 16'h7, 16'hf, 16'h2, 16'h0, 16'h1, 16'h3, 16'hb, 16'hb};
    logic [2:0]        tt [10] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h3, 3'h1, 3'h4, 3'h0};
    dcw_control_word_decoder u_dut (.*);
    dcw_axil_master u_m (.*);
    initial forever #25 aclk = ~aclk;
    // Pairs each bus answer with the oldest note and counts request pulses.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if (s_axi_bvalid && s_axi_bready) tg <= drive_req.target_valid ? drive_req.target : TGT_NONE;
        nf <= nf + drive_req.fault_reset;
        hs <= hs + drive_req.homing_start;
        he <= he + drive_req.homing_end;
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
        exp_q.push_back({e, 32'h0});
        u_m.wr(a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
        exp_q.push_back({e, d});
        u_m.rd(a);
    endtask
    // One more edge lets the monitor's captures of the answer cycle land before any check.
    task automatic cw(input logic [15:0] w);
        wr(CMD_ADDR, {16'h0, w});
        @(posedge aclk);
    endtask
    function automatic logic [4:0] lv();
        return {drive_req.jog_plus, drive_req.jog_minus, drive_req.jog_speed_sel, drive_req.homing_active};
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic results();
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CMD_ADDR, 32'h0);
        rd(MODE_ADDR, 32'hff);
        rd(STATUS_ADDR, 32'h1);
        rd(12'h0, 32'h0, RESP_SLVERR);
        wr(STATUS_ADDR, 32'h0, RESP_SLVERR);
        wr(AUX0_ADDR, 32'hffffffff);
        rd(AUX0_ADDR, 32'h1fff);
        chk(drive_req.aux_control, 16'h1fff);
        for (int i = 0; i < 10; i++) begin
            cw(tw[i]);
            chk(tg, tt[i]);
        end
        chk(drive_req.commanded_stop, 1'b1);
        cw(16'h3804);
        chk({drive_req.commanded_stop, drive_req.dynamic_brake, drive_req.neg_limit, drive_req.pos_limit}, 4'h7);
        cw(16'h0080);
        cw(16'h0080);
        chk(nf, 1);
        wr(MODE_ADDR, 32'h8c);
        cw(16'h0270);
        chk(lv(), 5'h1e);
        cw(16'h0010);
        chk(lv(), 5'h02);
        cw(16'hffff);
        rd(CMD_ADDR, 32'h3aff);
        cw(16'h0000);
        wr(MODE_ADDR, 32'h06);
        cw(16'h001f);
        chk(lv(), 5'h01);
        cw(16'h000f);
        chk({hs[1:0], he[1:0], lv()}, 9'h0a0);
        repeat (8) begin
            r = xs(r);
            cw(r[15:0]);
            rd(CMD_ADDR, {16'h0, r[15:0] & 16'h3aff});
        end
        results();
    end
endmodule
bind dcw_control_word_decoder dcw_properties u_chk (.*);
